// ---- common/word_pack_consts.svh ----
/*
  Bit positions, widths and reset values for the wide channel word packer.
  Assumes it is included by bare name wherever the positions are needed.
*/
`ifndef WORD_PACK_CONSTS_SVH
`define WORD_PACK_CONSTS_SVH

// ==========================================================================
// Word and lane geometry
`define WP_TX_WORD_W        44
`define WP_RX_WORD_W        64
`define WP_TX_LANES         4
`define WP_RX_LANES         2
`define WP_SYM_W            10
`define WP_BYTE_W           8
`define WP_TX_STRIDE        11
`define WP_TX_STRIDE_NARROW 22
`define WP_RX_FIELD_W       16
`define WP_RX_HI_SER_WIDE   16
`define WP_RX_HI_SER_NARROW 32

// ==========================================================================
// Transmit flag offsets inside an 11-bit lane
`define WP_TX_CTRL          8
`define WP_TX_FORCE_EN      9
`define WP_TX_FORCE_VAL     10

// ==========================================================================
// Receive flag offsets inside a 16-bit lane field
`define WP_RX_CTRL          8
`define WP_RX_CODE_ERR      9
`define WP_RX_SYNC          10
`define WP_RX_DISP_ERR      11
`define WP_RX_PATTERN       12
`define WP_RX_RM_DEL        13
`define WP_RX_RM_INS        14
`define WP_RX_RUN_DISP      15

// ==========================================================================
// Reset values
`define WP_RX_WORD_RESET    64'h0000_0000_0000_0000
`define WP_TX_DATA_RESET    10'h000

`endif

// ---- common/word_pack_pkg.sv ----
/*
  Types shared by the wide channel word packer.
  Assumes nothing of its surroundings.
*/
package word_pack_pkg;
  // ========================================================================
  // Configuration enumerations
  typedef enum logic [2:0] {IF_W8, IF_W10, IF_W16, IF_W32, IF_W40} if_width_t;
  typedef enum logic {SER_8_10, SER_16_20} coding_to_serializer_width_t;
  typedef enum logic [1:0] {MODE_8B10B, MODE_SONET, MODE_PCIE} coding_mode_t;
endpackage

// ---- src/rx_lane_pack.sv ----
/*
  Builds one 16-bit field of the wide receive word from one lane's status.
  Assumes the caller places the field and zeroes lanes it does not use.
*/
`timescale 1ns/100ps
`default_nettype none
`include "word_pack_consts.svh"

module rx_lane_pack
  import word_pack_pkg::*;
(
  input  wire if_width_t    if_width,
  input  wire coding_mode_t coding_mode,
  input  wire logic [9:0]   lane_data,
  input  wire logic         ctrl_det,
  input  wire logic         code_err,
  input  wire logic         sync_ok,
  input  wire logic         disp_err,
  input  wire logic         pattern_det,
  input  wire logic         rm_deleted,
  input  wire logic         rm_inserted,
  input  wire logic [1:0]   pipe_status,
  input  wire logic         running_disp,
  input  wire logic         framing_byte_size_flag,
  output logic [15:0]       lane_field
);

  // ==========================================================================
  // Field assembly. Bits that the width and mode leave open stay zero.
  always_comb begin
    lane_field = '0;
    if (if_width == IF_W10) begin
      lane_field[`WP_SYM_W-1:0]    = lane_data;                   // R11
      lane_field[`WP_RX_SYNC]      = sync_ok;                     // R11
      lane_field[`WP_RX_DISP_ERR]  = disp_err;                    // R11
      lane_field[`WP_RX_PATTERN]   = pattern_det;                 // R11
    end else begin
      lane_field[`WP_BYTE_W-1:0]   = lane_data[`WP_BYTE_W-1:0];   // R4
      if (coding_mode == MODE_SONET) begin
        // Only the narrow width carries framing flags; bit 11 is reserved.
        if (if_width == IF_W8) begin
          lane_field[`WP_RX_CTRL]    = framing_byte_size_flag;    // R10
          lane_field[`WP_RX_SYNC]    = sync_ok;                   // R10
          lane_field[`WP_RX_PATTERN] = pattern_det;               // R7
        end
      end else begin
        lane_field[`WP_RX_CTRL]      = ctrl_det;                  // R4
        lane_field[`WP_RX_CODE_ERR]  = code_err;                  // R5
        lane_field[`WP_RX_SYNC]      = sync_ok;                   // R6
        lane_field[`WP_RX_DISP_ERR]  = disp_err;                  // R6
        lane_field[`WP_RX_PATTERN]   = pattern_det;               // R7
      end
    end
    // Rate-compensation and disparity report only at the two narrow widths.
    if (if_width == IF_W8 || if_width == IF_W10) begin
      if (coding_mode == MODE_PCIE) begin
        lane_field[`WP_RX_RM_INS:`WP_RX_RM_DEL] = pipe_status;    // R8
      end else if (coding_mode == MODE_8B10B) begin
        lane_field[`WP_RX_RM_DEL]  = rm_deleted;                  // R8
        lane_field[`WP_RX_RM_INS]  = rm_inserted;                 // R8
      end
      if (coding_mode != MODE_SONET) begin
        lane_field[`WP_RX_RUN_DISP] = running_disp;               // R9
      end
    end
  end

endmodule
`default_nettype wire

// ---- src/transceiver_word_packing.sv ----
/*
  Wide channel word packer: splits the 44-bit transmit word into four
  coding lanes and packs two receive lanes into the 64-bit receive word.
  Assumes width and mode inputs come from logic on the same clock and are
  changed only while the channel carries no traffic.
*/
// Summary of operation
// [R1] 32-bit over 16/20: bytes at 7:0, 18:11, 29:22, 40:33, low first.
// [R2] 32-bit 8B/10B: control, force enable, force value at lane offsets 8-10.
// [R3] 40-bit over 20: ten-bit lanes at 9:0, 20:11, 31:22, 42:33.
// [R4] 8-bit 8B/10B receive: byte in 7:0, control flag on bit 8.
// [R5] 8-bit 8B/10B receive: code violation on bit 9.
// [R6] 8-bit 8B/10B receive: sync on bit 10, disparity error bit 11.
// [R7] 8-bit receive: alignment pattern detect on bit 12.
// [R8] 8/10-bit: deletion bit 13, insertion bit 14; PCIe puts status there.
// [R9] 8/10-bit: running disparity on bit 15.
// [R10] 8-bit SONET: size flag bit 8, sync 10, pattern 12, bit 11 reserved.
// [R11] 10-bit: raw symbol 9:0, sync 10, disparity error 11, pattern 12.
// [R12] 16-bit over 16/20: low byte 7:0, high byte 23:16.
// [R13] 16-bit 8B/10B: lane flags at offsets 8-12, upper lane bits 24-28.
// [R14] 16-bit over 8/10: high byte 39:32, low byte 7:0.
// [R15] Bits not assigned by width and mode are zero.
`timescale 1ns/100ps
`default_nettype none
`include "word_pack_consts.svh"

module transceiver_word_packing
  import word_pack_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire if_width_t                   if_width,
  input  wire coding_to_serializer_width_t coding_to_serializer_width,
  input  wire coding_mode_t                coding_mode,
  input  wire logic [43:0]                 tx_word_full,
  input  wire logic [1:0][9:0]             rx_lane_data,
  input  wire logic [1:0]                  rx_ctrl_det,
  input  wire logic [1:0]                  rx_code_err,
  input  wire logic [1:0]                  rx_sync_ok,
  input  wire logic [1:0]                  rx_disp_err,
  input  wire logic [1:0]                  rx_pattern_det,
  input  wire logic [1:0]                  rx_rm_deleted,
  input  wire logic [1:0]                  rx_rm_inserted,
  input  wire logic [1:0][1:0]             rx_pipe_status,
  input  wire logic [1:0]                  rx_running_disp,
  input  wire logic [1:0]                  framing_byte_size_flag,
  output logic [3:0][9:0]                  tx_lane_data_q,
  output logic [3:0]                       tx_lane_ctrl_q,
  output logic [3:0]                       tx_lane_force_en_q,
  output logic [3:0]                       tx_lane_force_val_q,
  output logic [63:0]                      rx_word_full_q
);

  // ==========================================================================
  // Decoding used only by the transmit split.
  function automatic int lanes_used(input if_width_t w);
    unique case (w)
      IF_W8, IF_W10:  lanes_used = 1;
      IF_W16:         lanes_used = 2;
      IF_W32, IF_W40: lanes_used = `WP_TX_LANES;
      default:        lanes_used = 0;
    endcase
  endfunction

  function automatic int tx_stride(input if_width_t w, input coding_to_serializer_width_t s);
    tx_stride = (w == IF_W16 && s == SER_8_10) ? `WP_TX_STRIDE_NARROW : `WP_TX_STRIDE;
  endfunction

  function automatic logic wide_symbols(input if_width_t w);
    wide_symbols = (w == IF_W10 || w == IF_W40);
  endfunction

  logic [3:0][9:0] tx_lane_data_d;
  logic [3:0]      tx_lane_ctrl_d;
  logic [3:0]      tx_lane_force_en_d;
  logic [3:0]      tx_lane_force_val_d;
  logic [1:0][15:0] rx_field;
  logic [63:0]     rx_word_full_d;

  // ==========================================================================
  // Transmit split. Lanes beyond the width's count stay zero so the coder
  // never sees stale bytes after a width change.
  always_comb begin
    int base;
    base = 0;
    tx_lane_data_d      = '0;
    tx_lane_ctrl_d      = '0;
    tx_lane_force_en_d  = '0;
    tx_lane_force_val_d = '0;
    for (int k = 0; k < `WP_TX_LANES; k++) begin
      if (k < lanes_used(if_width)) begin
        base = k * tx_stride(if_width, coding_to_serializer_width);
        if (wide_symbols(if_width)) begin
          tx_lane_data_d[k] = tx_word_full[base +: `WP_SYM_W];                   // R3
        end else begin
          tx_lane_data_d[k] = {2'h0, tx_word_full[base +: `WP_BYTE_W]};          // R1
          if (coding_mode != MODE_SONET) begin
            tx_lane_ctrl_d[k]      = tx_word_full[base + `WP_TX_CTRL];           // R2
            tx_lane_force_en_d[k]  = tx_word_full[base + `WP_TX_FORCE_EN];       // R2
            tx_lane_force_val_d[k] = tx_word_full[base + `WP_TX_FORCE_VAL];      // R2
          end
        end
      end
    end
    // The ten-bit width still carries a force value (idle request in PCIe).
    if (if_width == IF_W10 && coding_mode != MODE_SONET) begin
      tx_lane_force_val_d[0] = tx_word_full[`WP_TX_FORCE_VAL];
    end
  end

  // ==========================================================================
  // Receive lane fields, one packer per lane.
  for (genvar g = 0; g < `WP_RX_LANES; g++) begin : g_rx_lane
    rx_lane_pack u_pack (
      .if_width               (if_width),
      .coding_mode            (coding_mode),
      .lane_data              (rx_lane_data[g]),
      .ctrl_det               (rx_ctrl_det[g]),
      .code_err               (rx_code_err[g]),
      .sync_ok                (rx_sync_ok[g]),
      .disp_err               (rx_disp_err[g]),
      .pattern_det            (rx_pattern_det[g]),
      .rm_deleted             (rx_rm_deleted[g]),
      .rm_inserted            (rx_rm_inserted[g]),
      .pipe_status            (rx_pipe_status[g]),
      .running_disp           (rx_running_disp[g]),
      .framing_byte_size_flag (framing_byte_size_flag[g]),
      .lane_field             (rx_field[g])
    );
  end

  // ==========================================================================
  // Receive placement. The wide widths are not packed here and read zero.
  always_comb begin
    rx_word_full_d = '0;                                                          // R15
    unique case (if_width)
      IF_W8, IF_W10: rx_word_full_d[`WP_RX_FIELD_W-1:0] = rx_field[0];
      IF_W16: begin
        rx_word_full_d[`WP_RX_FIELD_W-1:0] = rx_field[0];                         // R12
        if (coding_to_serializer_width == SER_16_20) begin
          rx_word_full_d[`WP_RX_HI_SER_WIDE +: `WP_RX_FIELD_W] = rx_field[1];     // R13
        end else begin
          rx_word_full_d[`WP_RX_HI_SER_NARROW +: `WP_RX_FIELD_W] = rx_field[1];   // R14
        end
      end
      IF_W32, IF_W40: rx_word_full_d = '0;
      default:        rx_word_full_d = '0;
    endcase
  end

  // ==========================================================================
  // Transmit lane registers; one cycle of latency keeps outputs glitch free.
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_lane_data_q      <= {`WP_TX_LANES{`WP_TX_DATA_RESET}};
      tx_lane_ctrl_q      <= '0;
      tx_lane_force_en_q  <= '0;
      tx_lane_force_val_q <= '0;
    end else begin
      tx_lane_data_q      <= tx_lane_data_d;
      tx_lane_ctrl_q      <= tx_lane_ctrl_d;
      tx_lane_force_en_q  <= tx_lane_force_en_d;
      tx_lane_force_val_q <= tx_lane_force_val_d;
    end
  end

  // Receive word register.
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_word_full_q <= `WP_RX_WORD_RESET;
    end else begin
      rx_word_full_q <= rx_word_full_d;
    end
  end

  // ==========================================================================
  // Checks on the packing, each one cycle after the sampled inputs.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_tx32;
    if_width == IF_W32 && coding_to_serializer_width == SER_16_20;
  endsequence
  sequence s_rx8_coded;
    if_width == IF_W8 && coding_mode == MODE_8B10B;
  endsequence
  sequence s_rx16_wide;
    if_width == IF_W16 && coding_to_serializer_width == SER_16_20 && coding_mode == MODE_8B10B;
  endsequence

  property p_tx32_bytes;
    s_tx32 |=> tx_lane_data_q[1] == {2'h0, $past(tx_word_full[`WP_TX_STRIDE +: `WP_BYTE_W])}
           && tx_lane_data_q[3] == {2'h0, $past(tx_word_full[3*`WP_TX_STRIDE +: `WP_BYTE_W])};
  endproperty
  a_tx32_bytes: assert property (p_tx32_bytes) else $error("32-bit byte lane misplaced"); // R1

  property p_tx32_flags;
    s_tx32 ##0 coding_mode == MODE_8B10B |=>
      {tx_lane_force_val_q[3], tx_lane_force_en_q[3], tx_lane_ctrl_q[3]}
        == $past(tx_word_full[43:41]);
  endproperty
  a_tx32_flags: assert property (p_tx32_flags) else $error("Top lane flags misplaced"); // R2

  property p_tx40_lanes;
    if_width == IF_W40 |=> tx_lane_data_q[2] == $past(tx_word_full[2*`WP_TX_STRIDE +: `WP_SYM_W])
                        && tx_lane_data_q[3] == $past(tx_word_full[3*`WP_TX_STRIDE +: `WP_SYM_W]);
  endproperty
  a_tx40_lanes: assert property (p_tx40_lanes) else $error("40-bit lane misplaced"); // R3

  property p_rx8_data;
    s_rx8_coded |=> rx_word_full_q[7:0] == $past(rx_lane_data[0][7:0])
                 && rx_word_full_q[`WP_RX_CTRL] == $past(rx_ctrl_det[0]);
  endproperty
  a_rx8_data: assert property (p_rx8_data) else $error("Receive byte or control flag wrong"); // R4

  property p_rx8_code_err;
    s_rx8_coded |=> rx_word_full_q[`WP_RX_CODE_ERR] == $past(rx_code_err[0]);
  endproperty
  a_rx8_code_err: assert property (p_rx8_code_err) else $error("Code violation not flagged"); // R5

  property p_rx8_sync_disp;
    s_rx8_coded |=> rx_word_full_q[`WP_RX_DISP_ERR:`WP_RX_SYNC]
                    == {$past(rx_disp_err[0]), $past(rx_sync_ok[0])};
  endproperty
  a_rx8_sync_disp: assert property (p_rx8_sync_disp) else $error("Sync or disparity bit wrong"); // R6

  property p_rx8_pattern;
    if_width == IF_W8 ##0 rx_pattern_det[0] ##1 !rx_pattern_det[0]
      |-> rx_word_full_q[`WP_RX_PATTERN] ##1 !rx_word_full_q[`WP_RX_PATTERN];
  endproperty
  a_rx8_pattern: assert property (p_rx8_pattern) else $error("Pattern detect not one cycle late"); // R7

  property p_rx_pipe;
    if_width == IF_W8 && coding_mode == MODE_PCIE
      |=> rx_word_full_q[`WP_RX_RM_INS:`WP_RX_RM_DEL] == $past(rx_pipe_status[0]);
  endproperty
  a_rx_pipe: assert property (p_rx_pipe) else $error("PHY status not on bits 14:13"); // R8

  property p_rx_run_disp;
    (if_width == IF_W10 && coding_mode == MODE_8B10B)
      |=> rx_word_full_q[`WP_RX_RUN_DISP] == $past(rx_running_disp[0]);
  endproperty
  a_rx_run_disp: assert property (p_rx_run_disp) else $error("Running disparity wrong"); // R9

  property p_rx_sonet;
    if_width == IF_W8 && coding_mode == MODE_SONET
      |=> !rx_word_full_q[`WP_RX_DISP_ERR] && rx_word_full_q[`WP_RX_CTRL] == $past(framing_byte_size_flag[0]);
  endproperty
  a_rx_sonet: assert property (p_rx_sonet) else $error("Framing size flag or reserved bit wrong"); // R10

  property p_rx10;
    if_width == IF_W10 |=> rx_word_full_q[9:0] == $past(rx_lane_data[0]);
  endproperty
  a_rx10: assert property (p_rx10) else $error("Raw ten-bit symbol misplaced"); // R11

  property p_rx16_bytes;
    s_rx16_wide |=> rx_word_full_q[23:16] == $past(rx_lane_data[1][7:0])
                 && rx_word_full_q[63:29] == '0;
  endproperty
  a_rx16_bytes: assert property (p_rx16_bytes) else $error("16-bit high byte misplaced"); // R12

  property p_rx16_flags;
    s_rx16_wide |=> rx_word_full_q[28:24] == {$past(rx_pattern_det[1]), $past(rx_disp_err[1]),
                    $past(rx_sync_ok[1]), $past(rx_code_err[1]), $past(rx_ctrl_det[1])};
  endproperty
  a_rx16_flags: assert property (p_rx16_flags) else $error("Upper lane flags misplaced"); // R13

  property p_rx16_narrow;
    if_width == IF_W16 && coding_to_serializer_width == SER_8_10
      |=> rx_word_full_q[39:32] == $past(rx_lane_data[1][7:0]) && rx_word_full_q[31:16] == '0;
  endproperty
  a_rx16_narrow: assert property (p_rx16_narrow) else $error("Narrow serializer high byte wrong"); // R14

  property p_unused_zero;
    if_width == IF_W8 |=> rx_word_full_q[63:16] == '0 && tx_lane_data_q[3:1] == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("Unassigned bits not zero"); // R15

endmodule
`default_nettype wire

// ---- tb/fabric_user_model.sv ----
/*
  Fabric user logic model: sends the wide transmit word to the packer.
  Assumes the bench supplies the raw word and the channel configuration.
*/
`timescale 1ns/100ps
`default_nettype none

module fabric_user_model
  import word_pack_pkg::*;
(
  input  wire if_width_t                   if_width,
  input  wire coding_to_serializer_width_t coding_to_serializer_width,
  input  wire coding_mode_t                coding_mode,
  input  wire logic [43:0]                 raw_word,
  input  wire logic                        keep_unused_zero,
  output logic [43:0]                      tx_word_full
);
  // ==========================================================================
  // Bits that the chosen width and mode give a meaning to.
  function automatic logic [43:0] used_bits();
    logic [43:0] m;
    int          n;
    int          b;
    int          top;
    m   = '0;
    n   = (if_width inside {IF_W8, IF_W10}) ? 1 : (if_width == IF_W16) ? 2 : 4;
    top = (coding_mode == MODE_SONET) ? 7 : 10;
    if (if_width == IF_W40) top = 9;
    if (if_width == IF_W10) top = (coding_mode == MODE_SONET) ? 9 : 10;
    for (int k = 0; k < n; k++) begin
      b = (if_width == IF_W16 && coding_to_serializer_width == SER_8_10) ? k * 22 : k * 11;
      for (int i = 0; i <= top; i++) m[b + i] = 1'b1;
    end
    return m;
  endfunction

  // ==========================================================================
  // A polite sender zeroes unused bits; the careless one sets them to expose leaks.
  always_comb begin
    tx_word_full = keep_unused_zero ? (raw_word & used_bits()) : (raw_word | ~used_bits());
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the wide channel word packer.
  Assumes the design registers every output with a latency of one cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench
  import word_pack_pkg::*;
;
  // ==========================================================================
  // Stimulus and observation signals
  logic                        clock;
  logic                        reset;
  if_width_t                   if_width;
  coding_to_serializer_width_t ser;
  coding_mode_t                mode;
  logic [43:0]                 raw_word;
  logic                        keep_zero;
  wire logic [43:0]            tx_word_full;
  logic [1:0][9:0]             rx_lane_data;
  logic [1:0]                  ctl, cerr, sync, derr, pat, del, ins, rdisp, size;
  logic [1:0][1:0]             pipe;
  logic [3:0][9:0]             tx_lane_data_q;
  logic [3:0]                  tx_lane_ctrl_q;
  logic [3:0]                  tx_lane_force_en_q;
  logic [3:0]                  tx_lane_force_val_q;
  logic [63:0]                 rx_word_full_q;
  int                          n_mismatch = 0;
  int                          total_checks = 0;
  int                          seed = 24982;
  int                          cycles = 0;

  fabric_user_model fabric_user_model_i (.if_width(if_width), .coding_to_serializer_width(ser),
    .coding_mode(mode), .raw_word(raw_word), .keep_unused_zero(keep_zero), .tx_word_full(tx_word_full));

  transceiver_word_packing transceiver_word_packing_i (.clock(clock), .reset(reset), .if_width(if_width),
    .coding_to_serializer_width(ser), .coding_mode(mode), .tx_word_full(tx_word_full),
    .rx_lane_data(rx_lane_data), .rx_ctrl_det(ctl), .rx_code_err(cerr), .rx_sync_ok(sync),
    .rx_disp_err(derr), .rx_pattern_det(pat), .rx_rm_deleted(del), .rx_rm_inserted(ins),
    .rx_pipe_status(pipe), .rx_running_disp(rdisp), .framing_byte_size_flag(size),
    .tx_lane_data_q(tx_lane_data_q), .tx_lane_ctrl_q(tx_lane_ctrl_q),
    .tx_lane_force_en_q(tx_lane_force_en_q), .tx_lane_force_val_q(tx_lane_force_val_q),
    .rx_word_full_q(rx_word_full_q));

  // ==========================================================================
  // Clock and hang guard; the run needs well under a thousand cycles.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ==========================================================================
  // Expected lane outputs: data 40 bits, then control, force enable, force value.
  function automatic logic [51:0] exp_tx();
    logic [3:0][9:0] d;
    logic [3:0]      c, e, v;
    int              n, b;
    logic            ten;
    d = '0; c = '0; e = '0; v = '0;
    n   = (if_width inside {IF_W8, IF_W10}) ? 1 : (if_width == IF_W16) ? 2 : 4;
    ten = (if_width inside {IF_W10, IF_W40});
    for (int k = 0; k < n; k++) begin
      b = (if_width == IF_W16 && ser == SER_8_10) ? k * 22 : k * 11;
      d[k] = ten ? tx_word_full[b +: 10] : {2'b00, tx_word_full[b +: 8]};
      if (mode != MODE_SONET && !ten) begin
        c[k] = tx_word_full[b + 8];
        e[k] = tx_word_full[b + 9];
        v[k] = tx_word_full[b + 10];
      end
    end
    if (mode != MODE_SONET && if_width == IF_W10) v[0] = tx_word_full[10];
    return {d, c, e, v};
  endfunction

  // Expected receive word; wide widths and unassigned bits stay zero.
  function automatic logic [63:0] exp_rx();
    logic [63:0] w;
    logic [15:0] f;
    w = '0;
    if (if_width inside {IF_W32, IF_W40}) return w;
    for (int k = 0; k < ((if_width == IF_W16) ? 2 : 1); k++) begin
      f = '0;
      if (if_width == IF_W10) begin
        f = {rdisp[k], (mode == MODE_PCIE) ? pipe[k] : {ins[k], del[k]}, pat[k], derr[k], sync[k], rx_lane_data[k]};
        // SONET has no rate compensation or running disparity, so the top three bits stay clear.
        if (mode == MODE_SONET) f[15:13] = 3'h0;
      end else begin
        f[7:0] = rx_lane_data[k][7:0];
        if (mode == MODE_SONET) begin
          if (if_width == IF_W8) f[12:8] = {pat[k], 1'b0, sync[k], 1'b0, size[k]};
        end else begin
          f[12:8] = {pat[k], derr[k], sync[k], cerr[k], ctl[k]};
          if (if_width == IF_W8) f[15:13] = {rdisp[k], (mode == MODE_PCIE) ? pipe[k] : {ins[k], del[k]}};
        end
      end
      w[(k == 0) ? 0 : ((ser == SER_16_20) ? 16 : 32) +: 16] = f;
    end
    return w;
  endfunction

  // ==========================================================================
  // Comparison, stimulus and sequencing tasks.
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rand_in(input logic ones);
    raw_word  = ones ? '1 : 44'({$random(seed), $random(seed)});
    keep_zero = ones ? 1'b0 : 1'($random(seed));
    rx_lane_data = ones ? '1 : 20'($random(seed));
    {ctl, cerr, sync, derr, pat, del, ins, rdisp, size, pipe} = ones ? '1 : 22'($random(seed));
  endtask

  // Inputs stay put from one falling edge to the next, so the sample edge sees them.
  task automatic cycle_check();
    logic [51:0] e;
    @(posedge clock);
    @(negedge clock);
    e = exp_tx();
    check("tx_data", 64'(tx_lane_data_q), 64'(e[51:12]));
    check("tx_flags", 64'({tx_lane_ctrl_q, tx_lane_force_en_q, tx_lane_force_val_q}), 64'(e[11:0]));
    check("rx_word", rx_word_full_q, exp_rx());
  endtask

  task automatic check_zero();
    check("tx_zero", 64'({tx_lane_data_q, tx_lane_ctrl_q, tx_lane_force_en_q, tx_lane_force_val_q}), 64'h0);
    check("rx_zero", rx_word_full_q, 64'h0);
  endtask

  // One random input set is held through reset so the clearing is seen against live inputs.
  // The first edge after release already loads the live inputs, so it is checked as traffic.
  task automatic do_reset(input int n);
    reset = 1'b1;
    rand_in(1'b0);
    repeat (n) @(posedge clock);
    @(negedge clock);
    check_zero();
    reset = 1'b0;
    cycle_check();
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================================
  // Every width, serializer width and mode: an all-ones corner, then random words.
  initial begin
    if_width = IF_W8;
    ser = SER_8_10;
    mode = MODE_8B10B;
    do_reset(10);
    for (int wi = 0; wi < 5; wi++) begin
      for (int si = 0; si < 2; si++) begin
        for (int mi = 0; mi < 3; mi++) begin
          if_width = if_width_t'(wi);
          ser = coding_to_serializer_width_t'(si);
          mode = coding_mode_t'(mi);
          rand_in(1'b1);
          cycle_check();
          repeat (20) begin
            rand_in(1'b0);
            cycle_check();
          end
        end
      end
      if (wi == 2) do_reset(2);
    end
    test_done();
  end
endmodule
`default_nettype wire
